// ===== hw/mre_pkg.sv
// constants and types for the reset and processor mode entry block
// assumes one 25 MHz core clock and a 32-bit register bus with byte addresses
`default_nettype none
package mre_pkg;
  // timing
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned STRETCH_NS = 640;
  localparam int unsigned STRETCH_CYC = (STRETCH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] STRETCH_LAST = CNT_W'(STRETCH_CYC - 1);
  // register byte addresses
  localparam logic [7:0] ADDR_PMR0 = 8'h00;
  localparam logic [7:0] ADDR_CMR0 = 8'h04;
  localparam logic [7:0] ADDR_CSPR = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  // field positions
  localparam int unsigned PM_SWRST = 3;
  localparam int unsigned CM_WDT_SEL = 6;
  localparam int unsigned ST_CAUSE_PIN = 4;
  localparam int unsigned ST_CAUSE_SW = 5;
  localparam int unsigned ST_CAUSE_WDT = 6;
  localparam int unsigned ST_RAM_BAD = 7;
  localparam int unsigned ST_SUPPLY = 8;
  localparam int unsigned ST_MICRO_BOOT = 9;
  // mode select codes
  localparam logic [1:0] SEL_SINGLE = 2'h0;
  localparam logic [1:0] SEL_EXPAND = 2'h1;
  localparam logic [1:0] SEL_MICRO = 2'h3;
  // reset values
  localparam logic [7:0] CMR0_RST = 8'h00;
  localparam logic [7:0] CSPR_RST = 8'h00;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // synchronised inputs
  localparam int unsigned SYNC_W = 5;
  localparam int unsigned SY_RST = 0;
  localparam int unsigned SY_SUP = 1;
  localparam int unsigned SY_MODE = 2;
  localparam int unsigned SY_BOOT = 3;
  localparam int unsigned SY_HOLD = 4;
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h18;
  // bus control pins driven during reset
  localparam int unsigned BP_W = 5;
  localparam int unsigned BP_WR = 0;
  localparam int unsigned BP_RD = 1;
  localparam int unsigned BP_BCLK = 2;
  localparam int unsigned BP_HACK = 3;
  localparam int unsigned BP_HIGH = 4;
  typedef enum logic [1:0] {SEQ_HOLD, SEQ_STRETCH, SEQ_RUN} mre_seq_type;
  typedef enum logic [1:0] {MODE_SINGLE, MODE_EXPAND, MODE_MICRO, MODE_BOOT} mre_mode_type;
endpackage
`default_nettype wire

// ===== hw/mre_reg_if.sv
// register access carrier between the bus slave and the register file
// assumes both ends run on core_clk
`timescale 1ns/1ps
`default_nettype none
interface mre_reg_if;
  logic wr_en;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [7:0] raddr;
  logic [31:0] rdata;
  logic wr_ok;
  logic rd_ok;
  modport slave (output wr_en, waddr, wdata, wstrb, raddr, input rdata, wr_ok, rd_ok);
  modport regs (input wr_en, waddr, wdata, wstrb, raddr, output rdata, wr_ok, rd_ok);
endinterface
`default_nettype wire

// ===== hw/mre_pin_sync.sv
// three-stage synchronisers for the asynchronous pins
// assumes pins may change at any time; output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module mre_pin_sync import mre_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [SYNC_W-1:0] pin_in,
  output logic [SYNC_W-1:0] pin_q
);
  logic [SYNC_W-1:0] s1_reg;
  logic [SYNC_W-1:0] s2_reg;
  logic [SYNC_W-1:0] s3_reg;
  genvar i;
  // one chain per pin; stage one feeds stage two only
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          s1_reg[i] <= SYNC_RST[i];
          s2_reg[i] <= SYNC_RST[i];
          s3_reg[i] <= SYNC_RST[i];
          pin_q[i] <= SYNC_RST[i];
        end else begin
          s1_reg[i] <= pin_in[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          // agreement filters a single-cycle metastable settle
          if (s2_reg[i] == s3_reg[i]) begin
            pin_q[i] <= s3_reg[i];
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== hw/mre_axil_slave.sv
// axi4-lite slave front end for the reset and mode registers
// assumes one write and one read in flight at most; register file decodes addresses
`timescale 1ns/1ps
`default_nettype none
module mre_axil_slave import mre_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  mre_reg_if.slave rb
);
  logic aw_hold_reg;
  logic w_hold_reg;
  logic rd_pend_reg;
  // commit once both halves are held and no response is pending
  assign rb.wr_en = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  // write channels, taken in either order
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      rb.waddr <= 8'h00;
      rb.wdata <= 32'h0;
      rb.wstrb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        rb.waddr <= s_axi_awaddr;
        aw_hold_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        rb.wdata <= s_axi_wdata;
        rb.wstrb <= s_axi_wstrb;
        w_hold_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (rb.wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= rb.wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // read channel: address held one cycle, then data from the register mux
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      rd_pend_reg <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
      rb.raddr <= 8'h00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rb.raddr <= s_axi_araddr;
        s_axi_arready <= 1'b0;
        rd_pend_reg <= 1'b1;
      end else if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rb.rdata;
        s_axi_rresp <= rb.rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/mre_reset_mode.sv
// reset sequencer and processor mode selection with its register file
// assumes core_clk is the running main oscillator; pins arrive asynchronously
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mre_reset_mode import mre_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic reset_pin_n,
  input wire logic supply_stable,
  input wire logic mode_entry_pin,
  input wire logic boot_entry_pin,
  input wire logic bus_hold_req_n,
  input wire logic wdt_underflow,
  input wire logic ram_wr_active,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic cpu_reset_n,
  output logic cpu_vector_fetch,
  output logic port_force_reset,
  output logic osc_restart,
  output logic pullup_allow,
  output logic bus_ports_en,
  output logic int_rom_en,
  output logic boot_rom_sel,
  output logic [7:0] count_source_prescaler,
  output logic [BP_W-1:0] bus_pin_out,
  output logic [BP_W-1:0] bus_pin_oe
);
  mre_reg_if rbus ();
  logic [SYNC_W-1:0] pins_q;
  logic pin_n;
  logic pin_n_d_reg;
  logic sup_ok;
  mre_seq_type seq_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [1:0] mode_sel_reg;
  logic boot_reg;
  logic micro_start_reg;
  logic [7:0] clock_mode_reg0_reg;
  logic [7:0] count_source_prescaler_reg;
  logic sw_req_reg;
  logic soft_trig;
  logic cause_pin_reg;
  logic cause_sw_reg;
  logic cause_wdt_reg;
  logic ram_bad_reg;
  logic bclk_reg;
  logic in_run;
  logic wr_low;
  mre_mode_type mode_now;

  mre_pin_sync u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in({bus_hold_req_n, boot_entry_pin, mode_entry_pin, supply_stable, reset_pin_n}),
    .pin_q(pins_q)
  );

  mre_axil_slave u_bus (
    .core_clk(core_clk),
    .nrst(nrst),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .rb(rbus.slave)
  );

  // synchronised pin levels
  assign pin_n = pins_q[SY_RST];
  assign sup_ok = pins_q[SY_SUP];
  assign in_run = (seq_reg == SEQ_RUN);
  // only the low byte holds writable register bits
  assign wr_low = rbus.wr_en & rbus.wstrb[0];
  // watchdog only resets when its select bit asks for it
  assign soft_trig = sw_req_reg | (wdt_underflow & clock_mode_reg0_reg[CM_WDT_SEL]);

  // reset sequence: pin hold, release stretch, run
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      seq_reg <= SEQ_HOLD;
      cnt_reg <= '0;
    end else if (!pin_n) begin
      seq_reg <= SEQ_HOLD;
      cnt_reg <= '0;
    end else begin
      case (seq_reg)
        SEQ_HOLD: begin
          // release only after the synchronised rising edge
          seq_reg <= SEQ_STRETCH;
          cnt_reg <= '0;
        end
        SEQ_STRETCH: begin
          if (cnt_reg == STRETCH_LAST) begin
            seq_reg <= SEQ_RUN;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        SEQ_RUN: begin
          if (soft_trig) begin
            seq_reg <= SEQ_STRETCH;
            cnt_reg <= '0;
          end
        end
        default: begin
          seq_reg <= SEQ_HOLD;
        end
      endcase
    end
  end

  // software reset request bit is a self-clearing strobe
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sw_req_reg <= 1'b0;
    end else begin
      sw_req_reg <= in_run & wr_low & (rbus.waddr == ADDR_PMR0) & rbus.wdata[PM_SWRST];
    end
  end

  // mode state: pins steer it during hardware reset, software afterwards
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mode_sel_reg <= SEL_SINGLE;
      boot_reg <= 1'b0;
      micro_start_reg <= 1'b0;
    end else if (seq_reg == SEQ_HOLD) begin
      // last level seen before release is the one kept
      mode_sel_reg <= pins_q[SY_MODE] ? SEL_MICRO : SEL_SINGLE;
      boot_reg <= pins_q[SY_MODE] & ~pins_q[SY_BOOT];
      micro_start_reg <= pins_q[SY_MODE] & pins_q[SY_BOOT];
    end else if (in_run && wr_low && rbus.waddr == ADDR_PMR0) begin
      // 10b is not a mode; such a write leaves the selection alone
      if (rbus.wdata[1:0] != 2'h2) begin
        mode_sel_reg <= rbus.wdata[1:0];
        boot_reg <= 1'b0;
      end
    end
  end

  // clock mode register is cleared by every kind of reset
  always_ff @(posedge core_clk) begin
    if (!nrst || !in_run) begin
      clock_mode_reg0_reg <= CMR0_RST;
    end else if (wr_low && rbus.waddr == ADDR_CMR0) begin
      clock_mode_reg0_reg <= rbus.wdata[7:0];
    end
  end

  // prescaler survives software and watchdog resets
  always_ff @(posedge core_clk) begin
    if (!nrst || seq_reg == SEQ_HOLD) begin
      count_source_prescaler_reg <= CSPR_RST;
    end else if (in_run && wr_low && rbus.waddr == ADDR_CSPR) begin
      count_source_prescaler_reg <= rbus.wdata[7:0];
    end
  end

  // reset cause and ram damage flags
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cause_pin_reg <= 1'b0;
      cause_sw_reg <= 1'b0;
      cause_wdt_reg <= 1'b0;
      ram_bad_reg <= 1'b0;
      pin_n_d_reg <= 1'b0;
    end else begin
      pin_n_d_reg <= pin_n;
      if (seq_reg == SEQ_HOLD) begin
        cause_pin_reg <= 1'b1;
        cause_sw_reg <= 1'b0;
        cause_wdt_reg <= 1'b0;
      end else if (in_run && soft_trig) begin
        cause_pin_reg <= 1'b0;
        cause_sw_reg <= sw_req_reg;
        cause_wdt_reg <= ~sw_req_reg;
      end
      // ram flag is untouched by the pin reset; the set beats a clear
      if (pin_n_d_reg && !pin_n && ram_wr_active) begin
        ram_bad_reg <= 1'b1;
      end else if (wr_low && rbus.waddr == ADDR_STAT && rbus.wdata[ST_RAM_BAD]) begin
        ram_bad_reg <= 1'b0;
      end
    end
  end

  // effective processor mode
  always_comb begin
    if (boot_reg) begin
      mode_now = MODE_BOOT;
    end else if (mode_sel_reg == SEL_MICRO) begin
      mode_now = MODE_MICRO;
    end else if (mode_sel_reg == SEL_EXPAND) begin
      mode_now = MODE_EXPAND;
    end else begin
      mode_now = MODE_SINGLE;
    end
  end

  // reset and memory map outputs, all registered
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cpu_reset_n <= 1'b0;
      cpu_vector_fetch <= 1'b0;
      port_force_reset <= 1'b1;
      osc_restart <= 1'b1;
      pullup_allow <= 1'b0;
      bus_ports_en <= 1'b0;
      int_rom_en <= 1'b0;
      boot_rom_sel <= 1'b0;
      count_source_prescaler <= CSPR_RST;
    end else begin
      cpu_reset_n <= in_run;
      cpu_vector_fetch <= in_run & ~cpu_reset_n;
      port_force_reset <= ~in_run;
      osc_restart <= (seq_reg == SEQ_HOLD);
      // pull-ups stay off until the supply is known good
      pullup_allow <= sup_ok;
      bus_ports_en <= (mode_now == MODE_MICRO) || (mode_now == MODE_EXPAND);
      // a part that woke in micro mode keeps its rom off until the next pin reset
      int_rom_en <= (mode_now != MODE_MICRO) && !micro_start_reg;
      boot_rom_sel <= (mode_now == MODE_BOOT);
      count_source_prescaler <= count_source_prescaler_reg;
    end
  end

  // bus strobes during reset in micro mode, only once supply is stable
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bclk_reg <= 1'b0;
      bus_pin_out <= '0;
      bus_pin_oe <= '0;
    end else begin
      bclk_reg <= ~bclk_reg;
      bus_pin_out[BP_WR] <= 1'b1;
      bus_pin_out[BP_RD] <= 1'b1;
      bus_pin_out[BP_BCLK] <= bclk_reg;
      bus_pin_out[BP_HACK] <= pins_q[SY_HOLD];
      bus_pin_out[BP_HIGH] <= 1'b1;
      bus_pin_oe <= {BP_W{~in_run & sup_ok & (mode_now == MODE_MICRO)}};
    end
  end

  // address hits
  assign rbus.wr_ok = (rbus.waddr == ADDR_PMR0) || (rbus.waddr == ADDR_CMR0) ||
                      (rbus.waddr == ADDR_CSPR) || (rbus.waddr == ADDR_STAT);

  // read mux; unmapped words read zero with an error response
  always_comb begin
    rbus.rdata = 32'h0;
    rbus.rd_ok = 1'b1;
    if (rbus.raddr == ADDR_PMR0) begin
      rbus.rdata[1:0] = mode_sel_reg;
    end else if (rbus.raddr == ADDR_CMR0) begin
      rbus.rdata[7:0] = clock_mode_reg0_reg;
    end else if (rbus.raddr == ADDR_CSPR) begin
      rbus.rdata[7:0] = count_source_prescaler_reg;
    end else if (rbus.raddr == ADDR_STAT) begin
      rbus.rdata[1:0] = mode_now;
      rbus.rdata[ST_CAUSE_PIN] = cause_pin_reg;
      rbus.rdata[ST_CAUSE_SW] = cause_sw_reg;
      rbus.rdata[ST_CAUSE_WDT] = cause_wdt_reg;
      rbus.rdata[ST_RAM_BAD] = ram_bad_reg;
      rbus.rdata[ST_SUPPLY] = sup_ok;
      rbus.rdata[ST_MICRO_BOOT] = micro_start_reg;
    end else begin
      rbus.rd_ok = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/mre_reset_mode_asserts.sv
// concurrent checks on the top ports of the reset and mode block
// assumes it is bound into mre_reset_mode; one clock, nrst synchronous
`timescale 1ns/1ps
`default_nettype none
module mre_reset_mode_asserts import mre_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic supply_stable,
  input wire logic bus_hold_req_n,
  input wire logic cpu_reset_n,
  input wire logic cpu_vector_fetch,
  input wire logic port_force_reset,
  input wire logic osc_restart,
  input wire logic pullup_allow,
  input wire logic bus_ports_en,
  input wire logic int_rom_en,
  input wire logic boot_rom_sel,
  input wire logic [7:0] count_source_prescaler,
  input wire logic [BP_W-1:0] bus_pin_out,
  input wire logic [BP_W-1:0] bus_pin_oe
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // release and vector fetch, stretch after the pin lets go
  AST_VEC_ON_RISE: assert property (cpu_vector_fetch == $rose(cpu_reset_n))
    else $error("vector fetch not tied to cpu reset release");
  AST_STRETCH: assert property ($fell(osc_restart) |-> !cpu_reset_n[*8] ##1 !cpu_reset_n[*6] ##[1:6] cpu_reset_n)
    else $error("cpu reset stretch length wrong");
  AST_FORCE_ON_FALL: assert property ($fell(cpu_reset_n) |-> ##[0:1] port_force_reset)
    else $error("ports not forced during reset");
  AST_OSC_FORCE: assert property (osc_restart |-> port_force_reset)
    else $error("oscillator restart without port reset");
  // bus pins driven in micro mode reset
  AST_STROBES: assert property (bus_pin_oe[BP_WR] |-> bus_pin_out[BP_WR] && bus_pin_out[BP_RD] && bus_pin_out[BP_HIGH])
    else $error("strobes not high while driven");
  AST_BCLK: assert property (bus_pin_oe[BP_BCLK] && $past(bus_pin_oe[BP_BCLK]) |-> bus_pin_out[BP_BCLK] != $past(bus_pin_out[BP_BCLK]))
    else $error("bus clock not toggling");
  AST_HOLD_ACK: assert property ($stable(bus_hold_req_n)[*6] ##0 bus_pin_oe[BP_HACK] |-> bus_pin_out[BP_HACK] == bus_hold_req_n)
    else $error("hold ack does not follow hold request");
  // sync needs a few edges, so six quiet cycles are required first
  AST_SUPPLY_OFF: assert property (!supply_stable[*6] |-> !pullup_allow && bus_pin_oe == 5'h00)
    else $error("pins enabled before supply stable");
  AST_MICRO_MAP: assert property (bus_pin_oe[BP_WR] && $past(bus_pin_oe[BP_WR]) |-> bus_ports_en && !int_rom_en)
    else $error("micro mode map wrong");
  AST_BOOT_MAP: assert property (boot_rom_sel |-> !bus_ports_en)
    else $error("boot mode with bus ports");
  AST_PRESC_KEEP: assert property (!cpu_reset_n && !osc_restart && !$past(osc_restart) |-> $stable(count_source_prescaler))
    else $error("prescaler changed during internal reset");
endmodule
bind mre_reset_mode mre_reset_mode_asserts u_chk (
  .core_clk, .nrst, .supply_stable, .bus_hold_req_n, .cpu_reset_n, .cpu_vector_fetch,
  .port_force_reset, .osc_restart, .pullup_allow, .bus_ports_en, .int_rom_en, .boot_rom_sel,
  .count_source_prescaler, .bus_pin_out, .bus_pin_oe
);
`default_nettype wire

// ===== testbench/mre_reset_src.sv
// board reset source: supply ramp at time zero, then reset pulses on request
// assumes go is a one-cycle request raised while the pin is high
`timescale 1ns/1ps
`default_nettype none
module mre_reset_src #(
  parameter int RAMP = 24,
  parameter int HOLD = 20
) (
  input wire logic core_clk,
  input wire logic go,
  output logic reset_pin_n = 1'b0,
  output logic supply_stable = 1'b0
);
  // start values sit on the ports so each output has one driving process
  int cnt = 0;
  // pin held low over the ramp, then at least HOLD clocks more
  always @(posedge core_clk) begin
    if (go) begin
      cnt <= 0;
      reset_pin_n <= 1'b0;
    end else if (!reset_pin_n) begin
      cnt <= cnt + 1;
      if (cnt == RAMP) supply_stable <= 1'b1;
      if (cnt >= RAMP + HOLD) reset_pin_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the reset and processor mode block
// assumes mre_pkg, the design files, the checker and the reset source model
`timescale 1ns/1ps
`default_nettype none
module tb_top import mre_pkg::*;;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic rst_go = 1'b0;
  logic mode_entry_pin = 1'b0, boot_entry_pin = 1'b1, bus_hold_req_n = 1'b1;
  logic wdt_underflow = 1'b0, ram_wr_active = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd;
  logic [1:0] rs;
  logic reset_pin_n, supply_stable, cpu_reset_n, cpu_vector_fetch, port_force_reset, osc_restart;
  logic pullup_allow, bus_ports_en, int_rom_en, boot_rom_sel;
  logic [7:0] count_source_prescaler;
  logic [BP_W-1:0] bus_pin_out, bus_pin_oe;
  int err_count = 0;
  int n_compared = 0;
  // 25 MHz clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  mre_reset_mode dut (.core_clk, .nrst, .reset_pin_n, .supply_stable, .mode_entry_pin, .boot_entry_pin,
    .bus_hold_req_n, .wdt_underflow, .ram_wr_active, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .cpu_reset_n, .cpu_vector_fetch, .port_force_reset, .osc_restart, .pullup_allow, .bus_ports_en,
    .int_rom_en, .boot_rom_sel, .count_source_prescaler, .bus_pin_out, .bus_pin_oe);
  mre_reset_src u_src (.core_clk, .go(rst_go), .reset_pin_n, .supply_stable);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] time %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // bus write: each channel released at its own handshake edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
      end
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end while (s_axi_arvalid || s_axi_rready);
  endtask
  // no fixed latency assumed; the watchdog cuts a hang
  task automatic wait_cpu(input logic v);
    do @(posedge core_clk); while (cpu_reset_n !== v);
  endtask
  task automatic pin_reset(input logic me, input logic be);
    mode_entry_pin <= me;
    boot_entry_pin <= be;
    rst_go <= 1'b1;
    @(posedge core_clk);
    rst_go <= 1'b0;
    wait_cpu(1'b0);
  endtask
  task automatic wd_pulse();
    wdt_underflow <= 1'b1;
    @(posedge core_clk);
    wdt_underflow <= 1'b0;
  endtask
  task automatic t_por();
    wait_cpu(1'b1);
    axr(ADDR_CMR0, rd, rs);
    chk(rd, {24'h0, CMR0_RST});
    axr(ADDR_CSPR, rd, rs);
    chk(rd, {24'h0, CSPR_RST});
    axr(ADDR_STAT, rd, rs);
    chk(rd & 32'h0000_0103, 32'h0000_0100);
    chk({int_rom_en, bus_ports_en, boot_rom_sel, pullup_allow}, 4'h9);
    axr(8'h10, rd, rs);
    chk(rs, RESP_SLVERR);
    chk(rd, 32'h0);
    axw(8'h10, 32'hFFFF_FFFF, rs);
    chk(rs, RESP_SLVERR);
  endtask
  // 10b is not a mode code and must leave micro mode in place
  task automatic t_modes();
    logic [1:0] sel [4] = '{SEL_EXPAND, SEL_MICRO, 2'h2, SEL_SINGLE};
    logic [1:0] st [4] = '{2'h1, 2'h2, 2'h2, 2'h0};
    for (int i = 0; i < 4; i++) begin
      axw(ADDR_PMR0, {30'h0, sel[i]}, rs);
      axr(ADDR_STAT, rd, rs);
      chk(rs, RESP_OKAY);
      chk(rd[1:0], st[i]);
      chk({bus_ports_en, int_rom_en}, {st[i] != 2'h0, st[i] != 2'h2});
    end
  endtask
  task automatic t_sw();
    axw(ADDR_CSPR, 32'hFFFF_FF5A, rs);
    chk(rs, RESP_OKAY);
    axw(ADDR_CMR0, 32'h0000_0040, rs);
    axw(ADDR_PMR0, 32'h0000_0009, rs);
    wait_cpu(1'b0);
    @(posedge core_clk);
    chk(port_force_reset, 1'b1);
    wait_cpu(1'b1);
    axr(ADDR_CSPR, rd, rs);
    chk(rd, 32'h0000_005A);
    chk(count_source_prescaler, 8'h5A);
    axr(ADDR_CMR0, rd, rs);
    chk(rd, 32'h0);
    axr(ADDR_STAT, rd, rs);
    chk(rd & 32'h0000_0033, 32'h0000_0021);
  endtask
  task automatic t_wdt();
    wd_pulse();
    repeat (4) @(posedge core_clk);
    chk(cpu_reset_n, 1'b1);
    axw(ADDR_CMR0, 32'h0000_0040, rs);
    wd_pulse();
    wait_cpu(1'b0);
    wait_cpu(1'b1);
    axr(ADDR_CSPR, rd, rs);
    chk(rd, 32'h0000_005A);
    axr(ADDR_STAT, rd, rs);
    chk(rd & 32'h0000_0073, 32'h0000_0041);
  endtask
  // micro entry with a ram write cut short, then boot, then back to single
  task automatic t_pin();
    ram_wr_active <= 1'b1;
    pin_reset(1'b1, 1'b1);
    ram_wr_active <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk({osc_restart, port_force_reset, bus_pin_oe}, 7'h7F);
    bus_hold_req_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk(bus_pin_out[BP_HACK], 1'b0);
    bus_hold_req_n <= 1'b1;
    wait_cpu(1'b1);
    axr(ADDR_STAT, rd, rs);
    chk(rd & 32'h0000_0293, 32'h0000_0292);
    chk({int_rom_en, bus_ports_en, count_source_prescaler}, 10'h100);
    axw(ADDR_PMR0, 32'h0, rs);
    chk(int_rom_en, 1'b0);
    axw(ADDR_STAT, 32'h0000_0080, rs);
    axr(ADDR_STAT, rd, rs);
    chk(rd[ST_RAM_BAD], 1'b0);
    pin_reset(1'b1, 1'b0);
    wait_cpu(1'b1);
    axr(ADDR_STAT, rd, rs);
    chk(rd[1:0], 2'h3);
    chk({boot_rom_sel, bus_ports_en}, 2'h2);
    pin_reset(1'b0, 1'b1);
    wait_cpu(1'b1);
    chk({boot_rom_sel, int_rom_en}, 2'h1);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    t_por();
    t_modes();
    t_sw();
    t_wdt();
    t_pin();
    print_verdict();
  end
  // the whole run needs well under 3000 clocks
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
